// *** fir_cvt_params.svh ***
// Offsets, field positions, reset values and codes for the unsigned datapath
`ifndef FIR_CVT_PARAMS_SVH
`define FIR_CVT_PARAMS_SVH

// Register byte offsets
`define PSW_OFS       8'h00
`define IRQ_STAT_OFS  8'h04
`define IRQ_MASK_OFS  8'h08
`define UNMAPPED_OFS  8'hff

// Status word exception flag and rounding mode field positions
`define FLAG_DBZ      0
`define FLAG_INX      1
`define FLAG_UNF      2
`define FLAG_OVF      3
`define FLAG_INV      4
`define FLAG_IFZ      5
`define FLAG_OFZ      6
`define RMODE_LSB     8

// Reset values
`define FLAGS_RST     7'h00
`define RMODE_RST     2'h0
`define MASK_RST      4'h0

// Rounding mode codes
`define RM_NEAREST    2'h0
`define RM_ZERO       2'h1
`define RM_UP         2'h2
`define RM_DOWN       2'h3

// Interrupt event bit positions
`define EV_HALFWORD   0
`define EV_BYTE       1
`define EV_CONVERT    2
`define EV_EXCEPTION  3

// Halfword sum upper bound
`define HW_CLIP       32'h0fffffff

// Issue slots
`define SLOT_MAC_A    3'h2
`define SLOT_MAC_B    3'h3
`define SLOT_CVT_A    3'h1
`define SLOT_CVT_B    3'h4

// Single-precision exponent landmarks
`define EXP_MAX       8'hff
`define EXP_HALF      8'h7e
`define EXP_ONE       8'h7f
`define EXP_OVER      8'h9f

// Bus codes
`define HSIZE_WORD    3'h2

`endif

// *** fir_cvt_pkg.sv ***
// Types shared by the unsigned dot-product and conversion datapath
package fir_cvt_pkg;

    typedef enum logic [1:0] {
        halfword_dot_product_op,
        byte_dot_product_op,
        float_to_uint_op
    } op_kind_t;

    typedef struct packed {
        logic        valid;
        op_kind_t    op;
        logic [2:0]  slot;
        logic        guard;
        logic [31:0] first_source_reg;
        logic [31:0] second_source_reg;
    } issue_t;

    typedef struct packed {
        logic        valid;
        logic        guard;
        op_kind_t    op;
        logic [31:0] a;
        logic [31:0] b;
    } operand_stage_t;

    typedef struct packed {
        logic        valid;
        logic        guard;
        op_kind_t    op;
        logic [31:0] data;
        logic [6:0]  flags;
    } result_stage_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        op_kind_t    op;
        logic [31:0] data;
    } result_t;

    typedef struct packed {
        operand_stage_t s1;
        result_stage_t  s2;
        result_t        res;
        logic           refused;
        logic [6:0]     flags;
        logic [1:0]     rmode;
        logic [3:0]     irq_stat;
        logic [3:0]     irq_mask;
        logic           irq;
        logic           wr_pend;
        logic           rd_pend;
        logic [7:0]     addr;
        logic           ready;
        logic [31:0]    rdata;
    } core_state_t;

endpackage

// *** unsigned_fir_and_float_to_uint.sv ***
// Unsigned halfword/byte dot products and float-to-unsigned conversion
`timescale 1ns/1ps
`default_nettype none
`include "fir_cvt_params.svh"

// Function
// RQ1: Halfword op sums upper and lower products
// RQ2: Halfword sum full precision, clipped at top
// RQ3: Byte op sums four byte products unclipped
// RQ4: Guard LSB zero leaves destination unchanged
// RQ5: Conversion rounds per status word mode
// RQ6: Denormal input becomes zero, flush flag
// RQ7: Conversion exceptions set status word flags
// RQ8: Flags sticky, cleared only by status write
// RQ9: Flags update together with destination write
// RQ10: Simultaneous flag updates are ORed together
// RQ11: False guard leaves flags untouched too
// RQ12: Three-cycle latency, fixed legal issue slots
// RQ13: Out-of-range inputs saturate, raise invalid
module unsigned_fir_and_float_to_uint
    import fir_cvt_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Issue side
    input  wire issue_t      issue,
    input  wire logic [6:0]  ext_flag_updates,
    output result_t          result,
    output logic             issue_refused,
    // Status and interrupt
    output logic [31:0]      processor_status_word,
    output logic             irq
);

    core_state_t st;
    core_state_t next_st;
    logic        accept;
    logic        slot_ok;
    logic        psw_wr;
    logic        commit;
    logic [3:0]  irq_clear;
    logic [3:0]  events;
    logic [6:0]  flag_base;
    logic [32:0] hw_sum;
    logic [38:0] cvt;
    logic [31:0] rd_mux;

    // Halfword products, one bit of headroom for the sum
    function automatic logic [32:0] hw_dot(input logic [31:0] a, input logic [31:0] b);
        logic [31:0] hi;
        logic [31:0] lo;
        hi = a[31:16] * b[31:16];
        lo = a[15:0] * b[15:0];
        return {1'b0, hi} + {1'b0, lo};
    endfunction

    // Byte products; four of them never pass 18 bits
    function automatic logic [31:0] byte_dot(input logic [31:0] a, input logic [31:0] b);
        logic [31:0] acc;
        logic [15:0] p;
        acc = 32'h0;
        p = 16'h0;
        for (int i = 0; i < 4; i++) begin
            p = a[8*i+:8] * b[8*i+:8];
            acc = acc + {16'h0, p};
        end
        return acc;
    endfunction

    // Float to unsigned: returns {flags, value}
    function automatic logic [38:0] f2u(input logic [31:0] x, input logic [1:0] rm);
        logic        s;
        logic [7:0]  ex;
        logic [22:0] m;
        logic [55:0] w;
        logic [32:0] mag;
        logic        rb;
        logic        sb;
        logic        inc;
        logic [6:0]  fl;
        logic [31:0] r;
        s = x[31];
        ex = x[30:23];
        m = x[22:0];
        w = 56'h0;
        mag = 33'h0;
        rb = 1'b0;
        sb = 1'b0;
        inc = 1'b0;
        fl = 7'h0;
        r = 32'h0;
        if (ex == `EXP_MAX) begin
            // Infinity or NaN: only +inf gives all ones
            fl[`FLAG_INV] = 1'b1;
            r = (m == 23'h0 && !s) ? 32'hffffffff : 32'h0;
        end else if (ex == 8'h00) begin
            // Denormal flushed to zero before converting
            fl[`FLAG_IFZ] = (m != 23'h0);
        end else if (ex >= `EXP_OVER) begin
            // Magnitude of 2^32 or more
            fl[`FLAG_INV] = 1'b1;
            r = s ? 32'h0 : 32'hffffffff;
        end else begin
            // Fixed point: 32 integer bits over 24 fraction bits
            if (ex >= `EXP_HALF) begin
                w = 56'({1'b1, m}) << (ex - `EXP_HALF);
            end else begin
                sb = 1'b1;
            end
            rb = w[23];
            sb = sb | (|w[22:0]);
            case (rm)
                `RM_NEAREST: inc = rb & (sb | w[24]);
                `RM_ZERO:    inc = 1'b0;
                `RM_UP:      inc = (rb | sb) & ~s;
                `RM_DOWN:    inc = (rb | sb) & s;
                default:     inc = 1'b0;
            endcase
            mag = {1'b0, w[55:24]} + {32'h0, inc};
            if (s && mag != 33'h0) begin
                fl[`FLAG_INV] = 1'b1;
            end else if (mag[32]) begin
                fl[`FLAG_INV] = 1'b1;
                r = 32'hffffffff;
            end else begin
                fl[`FLAG_INX] = rb | sb;
                r = s ? 32'h0 : mag[31:0];
            end
        end
        return {fl, r};
    endfunction

    // Issue slot check per operation
    assign slot_ok = (issue.op == float_to_uint_op) ?
                     (issue.slot == `SLOT_CVT_A || issue.slot == `SLOT_CVT_B) :
                     ((issue.op == halfword_dot_product_op || issue.op == byte_dot_product_op) &&
                      (issue.slot == `SLOT_MAC_A || issue.slot == `SLOT_MAC_B)); // RQ12

    // Bus and commit qualifiers
    assign accept = hsel & hready & htrans[1] & (hsize == `HSIZE_WORD);
    assign psw_wr = st.wr_pend && (st.addr == `PSW_OFS);
    assign commit = st.s2.valid & st.s2.guard; // RQ4 RQ11

    // Next-state logic for pipeline, status word and bus
    always_comb begin
        next_st = st;
        hw_sum = hw_dot(st.s1.a, st.s1.b); // RQ1
        cvt = f2u(st.s1.a, st.rmode); // RQ5 RQ6 RQ13
        events = 4'h0;
        irq_clear = 4'h0;
        flag_base = st.flags;
        rd_mux = 32'h0;

        // Stage 1: capture legal issues only
        next_st.s1.valid = issue.valid & slot_ok; // RQ12
        next_st.s1.guard = issue.guard;
        next_st.s1.op = issue.op;
        next_st.s1.a = issue.first_source_reg;
        next_st.s1.b = issue.second_source_reg;
        next_st.refused = issue.valid & ~slot_ok;

        // Stage 2: compute
        next_st.s2.valid = st.s1.valid;
        next_st.s2.guard = st.s1.guard;
        next_st.s2.op = st.s1.op;
        next_st.s2.flags = 7'h0;
        case (st.s1.op)
            halfword_dot_product_op: begin
                next_st.s2.data = (hw_sum > {1'b0, `HW_CLIP}) ? `HW_CLIP : hw_sum[31:0]; // RQ2
            end
            byte_dot_product_op: begin
                next_st.s2.data = byte_dot(st.s1.a, st.s1.b); // RQ3
            end
            float_to_uint_op: begin
                next_st.s2.data = cvt[31:0];
                next_st.s2.flags = cvt[38:32]; // RQ7
            end
            default: begin
                next_st.s2.data = 32'h0;
            end
        endcase

        // Stage 3: destination held when the guard is false
        next_st.res.valid = st.s2.valid;
        next_st.res.write = commit; // RQ4
        next_st.res.op = st.s2.op;
        next_st.res.data = commit ? st.s2.data : st.res.data; // RQ4

        // Completion events for the interrupt status
        if (commit) begin
            case (st.s2.op)
                halfword_dot_product_op: events[`EV_HALFWORD] = 1'b1;
                byte_dot_product_op:     events[`EV_BYTE] = 1'b1;
                float_to_uint_op:        events[`EV_CONVERT] = 1'b1;
                default:                 events = 4'h0;
            endcase
            events[`EV_EXCEPTION] = |st.s2.flags;
        end

        // Register writes land in the data phase
        if (st.wr_pend) begin
            case (st.addr)
                `PSW_OFS: begin
                    flag_base = hwdata[6:0]; // RQ8
                    next_st.rmode = hwdata[`RMODE_LSB+:2];
                end
                `IRQ_STAT_OFS: irq_clear = hwdata[3:0];
                `IRQ_MASK_OFS: next_st.irq_mask = hwdata[3:0];
                default: ;
            endcase
        end

        // Sets win over the status write; all sources merge by OR
        next_st.flags = flag_base | ext_flag_updates | (commit ? st.s2.flags : 7'h0); // RQ8 RQ9 RQ10
        next_st.irq_stat = (st.irq_stat & ~irq_clear) | events;
        next_st.irq = |(next_st.irq_stat & next_st.irq_mask);

        // Address phase capture; wide addresses decode as unmapped
        next_st.wr_pend = accept & hwrite;
        next_st.rd_pend = accept & ~hwrite;
        if (accept) begin
            next_st.addr = (|haddr[31:8]) ? `UNMAPPED_OFS : haddr[7:0];
        end

        // Read mux; unmapped reads return zero
        case (st.addr)
            `PSW_OFS:      rd_mux = {22'h0, st.rmode, 1'b0, st.flags};
            `IRQ_STAT_OFS: rd_mux = {28'h0, st.irq_stat};
            `IRQ_MASK_OFS: rd_mux = {28'h0, st.irq_mask};
            default:       rd_mux = 32'h0;
        endcase

        // One wait state on reads so a write just before is seen
        if (accept & ~hwrite) begin
            next_st.ready = 1'b0;
        end else if (st.rd_pend) begin
            next_st.ready = 1'b1;
            next_st.rdata = rd_mux;
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
            st.ready <= 1'b1;
            st.flags <= `FLAGS_RST;
            st.rmode <= `RMODE_RST;
            st.irq_mask <= `MASK_RST;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from state, hresp tied to zero
    assign hreadyout = st.ready;
    assign hresp = 1'b0;
    assign hrdata = st.rdata;
    assign result = st.res;
    assign issue_refused = st.refused;
    assign processor_status_word = {22'h0, st.rmode, 1'b0, st.flags};
    assign irq = st.irq;

    // Checks
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_issue(op_kind_t k, logic g);
        issue.valid && slot_ok && issue.op == k && issue.guard == g;
    endsequence

    sequence s_conv_small;
        issue.valid && slot_ok && issue.op == float_to_uint_op && issue.guard &&
        !issue.first_source_reg[31] && issue.first_source_reg[30:23] != 8'h00 &&
        issue.first_source_reg[30:23] < `EXP_HALF;
    endsequence

    a_hw_sum_value: assert property ( // RQ1
        s_issue(halfword_dot_product_op, 1'b1) ##0 (hw_dot(issue.first_source_reg,
            issue.second_source_reg) <= {1'b0, `HW_CLIP})
        |-> ##3 result.write && result.data == 32'(hw_dot($past(issue.first_source_reg, 3),
            $past(issue.second_source_reg, 3))))
        else $error("halfword sum wrong");

    a_hw_clip_top: assert property ( // RQ2
        s_issue(halfword_dot_product_op, 1'b1) ##0
        (hw_dot(issue.first_source_reg, issue.second_source_reg) > {1'b0, `HW_CLIP})
        |-> ##3 result.data == `HW_CLIP)
        else $error("halfword sum not clipped");

    a_byte_sum_value: assert property ( // RQ3
        s_issue(byte_dot_product_op, 1'b1)
        |-> ##3 result.write && result.data == byte_dot($past(issue.first_source_reg, 3),
            $past(issue.second_source_reg, 3)))
        else $error("byte sum wrong");

    a_guard_keeps_dest: assert property ( // RQ4
        issue.valid && slot_ok && !issue.guard
        |-> ##3 result.valid && !result.write && $stable(result.data))
        else $error("false guard wrote destination");

    a_conv_round_up: assert property ( // RQ5
        s_conv_small ##1 (st.rmode == `RM_UP) |-> ##2 result.data == 32'h1)
        else $error("round up mode ignored");

    a_denorm_flush: assert property ( // RQ6
        s_issue(float_to_uint_op, 1'b1) ##0 (issue.first_source_reg[30:23] == 8'h00 &&
        issue.first_source_reg[22:0] != 23'h0)
        |-> ##3 result.data == 32'h0 && processor_status_word[`FLAG_IFZ])
        else $error("denormal not flushed");

    a_negative_invalid: assert property ( // RQ7
        s_issue(float_to_uint_op, 1'b1) ##0 (issue.first_source_reg[31] &&
        issue.first_source_reg[30:23] >= `EXP_ONE)
        |-> ##3 result.data == 32'h0 && processor_status_word[`FLAG_INV])
        else $error("negative input not invalid");

    a_flags_sticky: assert property ( // RQ8
        !$past(psw_wr) |-> ($past(st.flags) & ~st.flags) == 7'h0)
        else $error("flag cleared without status write");

    a_flags_with_dest: assert property ( // RQ9
        $past(commit && st.s2.op == float_to_uint_op)
        |-> result.write && (st.flags & $past(st.s2.flags)) == $past(st.s2.flags))
        else $error("flags not updated with destination");

    a_flags_or_merge: assert property ( // RQ10
        $past(ext_flag_updates) != 7'h0
        |-> (st.flags & $past(ext_flag_updates)) == $past(ext_flag_updates))
        else $error("simultaneous update lost");

    a_guard_no_flags: assert property ( // RQ11
        s_issue(float_to_uint_op, 1'b0) ##3
        ($past(ext_flag_updates) == 7'h0 && !$past(psw_wr))
        |-> st.flags == $past(st.flags))
        else $error("false guard touched flags");

    a_slot_refused: assert property ( // RQ12
        issue.valid && !slot_ok |=> issue_refused ##2 !result.valid)
        else $error("illegal slot not refused");

    a_inf_saturate: assert property ( // RQ13
        s_issue(float_to_uint_op, 1'b1) ##0 (issue.first_source_reg == 32'h7f800000)
        |-> ##3 result.data == 32'hffffffff && processor_status_word[`FLAG_INV])
        else $error("infinity not saturated");

endmodule
`default_nettype wire

// *** fir_cvt_core_model.sv ***
// Issue-side model: drives one op per request and keeps the destination register
`timescale 1ns/1ps
`default_nettype none
module fir_cvt_core_model
    import fir_cvt_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // Request from the bench and answer from the datapath
    input  wire issue_t      req,
    input  wire result_t     result,
    // Issue towards the datapath and the destination register
    output issue_t           issue,
    output logic [31:0]      dest
);
    // Idle operands toggle so a stale value never looks valid
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            issue <= '0;
            dest  <= '0;
        end else begin
            if (req.valid) begin
                issue <= req;
            end else begin
                issue.valid             <= 1'b0;
                issue.first_source_reg  <= ~issue.first_source_reg;
                issue.second_source_reg <= ~issue.second_source_reg;
            end
            // Register file only changes on a written result
            if (result.write === 1'b1) begin
                dest <= result.data;
            end
        end
    end
endmodule
`default_nettype wire

// *** unsigned_fir_and_float_to_uint_bench.sv ***
// Self-checking bench for the unsigned dot-product and conversion datapath
`timescale 1ns/1ps
`default_nettype none
`include "fir_cvt_params.svh"
module unsigned_fir_and_float_to_uint_bench
    import fir_cvt_pkg::*;
;
    localparam op_kind_t hw_op = halfword_dot_product_op;
    localparam op_kind_t by_op = byte_dot_product_op;
    localparam op_kind_t cv_op = float_to_uint_op;

    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = `HSIZE_WORD;
    logic [31:0] hwdata = 32'h0;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    issue_t      req = '0;
    issue_t      issue;
    logic [6:0]  ext_flag_updates = 7'h00;
    result_t     result;
    logic        issue_refused;
    logic [31:0] processor_status_word;
    logic        irq;
    logic [31:0] dest;
    logic [31:0] exp_dest = 32'h0;
    logic [31:0] rd;
    int          failures = 0;
    int          n_tests = 0;

    // Clock at 200 MHz
    always #2.5 hclk = ~hclk;

    unsigned_fir_and_float_to_uint unsigned_fir_and_float_to_uint_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .issue(issue),
        .ext_flag_updates(ext_flag_updates), .result(result), .issue_refused(issue_refused),
        .processor_status_word(processor_status_word), .irq(irq)
    );

    fir_cvt_core_model fir_cvt_core_model_inst (
        .hclk(hclk), .hresetn(hresetn), .req(req), .result(result),
        .issue(issue), .dest(dest)
    );

    task automatic wrap_up();
        if (failures == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic checkv(input logic [31:0] seen, input logic [31:0] expv);
        n_tests++;
        if (seen !== expv) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask

    // One single AHB-Lite transfer; the wait for hready is bounded
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rdv);
        int n;
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize  <= `HSIZE_WORD;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        // Address phase never taken counts as a failure
        if (hreadyout !== 1'b1) begin
            failures++;
            wrap_up();
        end
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 40);
        rdv = hrdata;
        if (hreadyout !== 1'b1) begin
            failures++;
            wrap_up();
        end
    endtask

    // Issue one op and watch six edges; sticky flag 0 is preset to prove flags survive
    task automatic run(input op_kind_t op, input logic [2:0] slot, input logic g,
                       input logic [1:0] rm, input logic [31:0] a, input logic [31:0] b,
                       input logic [31:0] x, input logic [6:0] fl, input logic [6:0] ext);
        int          lat;
        int          nv;
        int          nr;
        logic        bad;
        logic        wr;
        logic [31:0] data;
        logic [31:0] psw;
        bad = (op == cv_op) ? !(slot == `SLOT_CVT_A || slot == `SLOT_CVT_B)
                            : !(slot == `SLOT_MAC_A || slot == `SLOT_MAC_B);
        ahb(1'b1, `PSW_OFS, {22'h0, rm, 8'h01}, rd);
        @(posedge hclk);
        req <= '{1'b1, op, slot, g, a, b};
        @(posedge hclk);
        req <= '0;
        lat = 0;
        nv = 0;
        nr = 0;
        wr = 1'bx;
        for (int i = 1; i <= 6; i++) begin
            @(posedge hclk);
            // Other units report in the same edge as the result
            if (i == 2) ext_flag_updates <= ext;
            if (i == 3) ext_flag_updates <= 7'h00;
            #1;
            if (issue_refused === 1'b1) nr++;
            if (result.valid === 1'b1) begin
                nv++;
                lat = i;
                wr = result.write;
                data = result.data;
                psw = processor_status_word;
            end
        end
        if (bad) begin
            checkv(32'(nr), 32'h1);
            checkv(32'(nv), 32'h0);
        end else begin
            checkv(32'(lat), 32'h3);
            checkv({31'h0, wr}, {31'h0, g});
            if (g) checkv(data, x);
            checkv(psw, {22'h0, rm, 1'b0, 7'h01 | fl | ext});
            if (g) exp_dest = x;
        end
        checkv(dest, exp_dest);
    endtask

    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        // Reset values through the bus
        ahb(1'b0, `PSW_OFS, 32'h0, rd);
        checkv(rd, 32'h0);
        ahb(1'b0, `IRQ_MASK_OFS, 32'h0, rd);
        checkv(rd, 32'h0);
        checkv({31'h0, hresp}, 32'h0);
        // Halfword products, guard and clip
        run(hw_op, 3'h2, 1'b1, 2'h0, 32'h00020003, 32'h00010002, 32'h8, 7'h0, 7'h0);
        run(hw_op, 3'h3, 1'b0, 2'h0, 32'h80000064, 32'h00648000, 32'h0, 7'h0, 7'h0);
        run(hw_op, 3'h3, 1'b1, 2'h0, 32'h80000064, 32'h00648000, 32'h640000, 7'h0, 7'h0);
        run(hw_op, 3'h2, 1'b1, 2'h0, 32'h00020003, 32'h00648000, 32'h180c8, 7'h0, 7'h40);
        run(hw_op, 3'h2, 1'b1, 2'h0, 32'hffffffff, 32'hffffffff, `HW_CLIP, 7'h0, 7'h0);
        // Byte products, full precision
        run(by_op, 3'h2, 1'b1, 2'h0, 32'h0afb14f6, 32'h0a0a1414, 32'h1efa, 7'h0, 7'h0);
        run(by_op, 3'h3, 1'b0, 2'h0, 32'h0afb14f6, 32'h0a0a1414, 32'h0, 7'h0, 7'h0);
        run(by_op, 3'h3, 1'b1, 2'h0, 32'h649c649c, 32'h9c649c64, 32'hf3c0, 7'h0, 7'h0);
        run(by_op, 3'h2, 1'b1, 2'h0, 32'h80808080, 32'hffffffff, 32'h1fe00, 7'h0, 7'h0);
        run(by_op, 3'h3, 1'b1, 2'h0, 32'hffffffff, 32'hffffffff, 32'h3f804, 7'h0, 7'h0);
        // Conversion in every rounding mode and the special inputs
        run(cv_op, 3'h1, 1'b1, `RM_NEAREST, 32'h40400000, 32'h0, 32'h3, 7'h0, 7'h0);
        run(cv_op, 3'h4, 1'b1, `RM_NEAREST, 32'h40247ae1, 32'h0, 32'h3, 7'h02, 7'h0);
        run(cv_op, 3'h1, 1'b1, `RM_ZERO, 32'h40247ae1, 32'h0, 32'h2, 7'h02, 7'h0);
        run(cv_op, 3'h4, 1'b1, `RM_UP, 32'h40247ae1, 32'h0, 32'h3, 7'h02, 7'h0);
        run(cv_op, 3'h1, 1'b1, `RM_DOWN, 32'h40247ae1, 32'h0, 32'h2, 7'h02, 7'h0);
        run(cv_op, 3'h4, 1'b1, `RM_NEAREST, 32'h40200000, 32'h0, 32'h2, 7'h02, 7'h0);
        run(cv_op, 3'h4, 1'b1, `RM_UP, 32'h3e800000, 32'h0, 32'h1, 7'h02, 7'h0);
        run(cv_op, 3'h1, 1'b0, `RM_NEAREST, 32'hff4fffff, 32'h0, 32'h0, 7'h0, 7'h0);
        run(cv_op, 3'h4, 1'b1, `RM_NEAREST, 32'hff4fffff, 32'h0, 32'h0, 7'h10, 7'h0);
        run(cv_op, 3'h1, 1'b1, `RM_NEAREST, 32'h7f800000, 32'h0, 32'hffffffff, 7'h10, 7'h08);
        run(cv_op, 3'h4, 1'b1, `RM_NEAREST, 32'hbfc147ae, 32'h0, 32'h0, 7'h10, 7'h0);
        run(cv_op, 3'h1, 1'b1, `RM_NEAREST, 32'h00400000, 32'h0, 32'h0, 7'h20, 7'h0);
        run(cv_op, 3'h4, 1'b1, `RM_NEAREST, 32'hffffffff, 32'h0, 32'h0, 7'h10, 7'h0);
        run(cv_op, 3'h1, 1'b1, `RM_NEAREST, 32'h4f800000, 32'h0, 32'hffffffff, 7'h10, 7'h0);
        // Illegal slots are refused with no result
        run(hw_op, 3'h1, 1'b1, 2'h0, 32'h1, 32'h1, 32'h0, 7'h0, 7'h0);
        run(cv_op, 3'h2, 1'b1, 2'h0, 32'h40400000, 32'h0, 32'h0, 7'h0, 7'h0);
        // Status word written and read back over the bus
        ahb(1'b1, `PSW_OFS, 32'h00000355, rd);
        ahb(1'b0, `PSW_OFS, 32'h0, rd);
        checkv(rd, 32'h00000355);
        // Events latched, masked, then cleared by writing ones
        ahb(1'b0, `IRQ_STAT_OFS, 32'h0, rd);
        checkv(rd, 32'h0000000f);
        #1;
        checkv({31'h0, irq}, 32'h0);
        ahb(1'b1, `IRQ_MASK_OFS, 32'h4, rd);
        ahb(1'b0, `IRQ_MASK_OFS, 32'h0, rd);
        #1;
        checkv({31'h0, irq}, 32'h1);
        ahb(1'b1, `IRQ_STAT_OFS, 32'h4, rd);
        ahb(1'b0, `IRQ_STAT_OFS, 32'h0, rd);
        checkv(rd, 32'h0000000b);
        #1;
        checkv({31'h0, irq}, 32'h0);
        ahb(1'b1, `IRQ_STAT_OFS, 32'hf, rd);
        ahb(1'b0, `IRQ_STAT_OFS, 32'h0, rd);
        checkv(rd, 32'h0);
        // Unmapped place reads as zero
        ahb(1'b0, 8'h0c, 32'h0, rd);
        checkv(rd, 32'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
